// File: src/dispatch_sched_pkg.sv
package dispatch_sched_pkg;
  // ****************************************************
  // register map (byte addresses)
  // ****************************************************
  localparam logic [31:0] ADDR_THREAD_LAUNCH = 32'h80000000;
  localparam logic [31:0] ADDR_THREAD_END = 32'h80000004;
  localparam logic [31:0] ADDR_LAUNCH_AND_END = 32'h08000008;
  localparam logic [31:0] ADDR_SCHED_COMMAND = 32'h80001000;
  localparam logic [31:0] ADDR_SCHED_EVENT_TIME = 32'h80001004;
  localparam logic [31:0] ADDR_SCHED_CURRENT_TIME = 32'h80001008;

  // ****************************************************
  // field layout
  // ****************************************************
  localparam int START_ADDR_HI = 13;  // launch address bits [13:0]
  localparam int START_ADDR_LO = 0;
  localparam int CMD_OP_HI = 31;
  localparam int CMD_OP_LO = 29;
  localparam int CMD_PORT_HI = 11;
  localparam int CMD_PORT_LO = 8;
  localparam int CMD_PIN_HI = 7;
  localparam int CMD_PIN_LO = 0;
  localparam int ET_THREAD_BIT = 31;  // 1x: thread start
  localparam int ET_A0_LOAD_BIT = 30;  // x1: load a0
  localparam int ET_A0_HI = 29;
  localparam int ET_A0_LO = 14;
  localparam int TIME_HI = 22;  // event time field
  localparam int TIME_LO = 0;

  // ****************************************************
  // sizes, counts and priorities
  // ****************************************************
  localparam int ID_W = 4;
  localparam int NUM_SLOTS = 16;
  localparam int TIME_W = 23;
  localparam int LIST_DEPTH = 240;
  localparam logic [7:0] LIST_FULL = 8'hF0;
  localparam logic [TIME_W-1:0] LOOKBACK = 23'h000FFF;  // 4095 cycles
  localparam logic [2:0] EXEC_CYCLES = 3'h5;
  localparam logic [3:0] SAME_TIME_GAP = 4'h8;
  localparam logic [2:0] HEAD_BLOCK = 3'h7;
  localparam logic [13:0] BOOT_ADDR = 14'h0000;
  localparam int PRIO_LAUNCH = 6;
  localparam int PRIO_SCHED = 5;
  localparam int PRIO_GPIO = 4;
  localparam int PRIO_MSG = 3;
  localparam int PRIO_RX = 2;
  localparam int PRIO_TX = 1;
  localparam int NUM_SRC = 7;

  // ****************************************************
  // types
  // ****************************************************
  typedef struct packed {
    logic [13:0] addr;
    logic [15:0] a0;
    logic a0_load;
  } start_req_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic is_new;
    start_req_t req;
  } issue_t;

  typedef struct packed {
    logic [2:0] op;
    logic [3:0] port;
    logic [7:0] pins;
  } gpio_cmd_t;

  typedef struct packed {
    logic [TIME_W-1:0] time_at;
    logic [31:0] cmd;
    logic [31:0] et;
  } ev_t;

  typedef enum {INS_IDLE, INS_HEAD, INS_SCAN, INS_PUT} ins_state_t;
endpackage

// File: src/thread_dispatch_event_scheduler.sv
`timescale 1ns/100ps
module thread_dispatch_event_scheduler (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] wr_thread_i,  // thread issuing the bus access
  input wire logic ret_valid_i,  // thread leaving the pipeline
  input wire logic [3:0] ret_id_i,
  input wire logic [3:0] periph_valid_i,  // 3 gpio, 2 messaging, 1 rx, 0 tx
  input wire dispatch_sched_pkg::start_req_t [3:0] periph_req_i,
  output logic [3:0] periph_ready_o,
  output logic issue_valid_o,  // thread entering the pipeline
  output dispatch_sched_pkg::issue_t issue_o,
  output logic gpio_cmd_valid_o,
  output dispatch_sched_pkg::gpio_cmd_t gpio_cmd_o
);
  // ****************************************************
  // bus decode
  // ****************************************************
  logic ack;  // registered acknowledge
  logic boot_pend;  // initial thread not yet started
  logic [6:0] grant;
  logic sched_busy;
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack;
  wire full_word = &wb_sel_i;
  wire wr = bus_req & wb_we_i & full_word;
  wire hit_launch = wb_adr_i == dispatch_sched_pkg::ADDR_THREAD_LAUNCH;
  wire hit_end = wb_adr_i == dispatch_sched_pkg::ADDR_THREAD_END;
  wire hit_lae = wb_adr_i == dispatch_sched_pkg::ADDR_LAUNCH_AND_END;
  wire hit_cmd = wb_adr_i == dispatch_sched_pkg::ADDR_SCHED_COMMAND;
  wire hit_et = wb_adr_i == dispatch_sched_pkg::ADDR_SCHED_EVENT_TIME;
  wire hit_ct = wb_adr_i == dispatch_sched_pkg::ADDR_SCHED_CURRENT_TIME;
  wire launch_wr = wr & (hit_launch | hit_lae);
  wire sched_wr = wr & (hit_cmd | hit_et);
  // launch waits for a slot, scheduler writes wait for a running insertion
  wire acc = bus_req & (launch_wr ? (grant[dispatch_sched_pkg::PRIO_LAUNCH] & ~boot_pend) :
                        sched_wr ? ~sched_busy : 1'b1);
  wire end_wr = acc & wr & (hit_end | hit_lae);
  wire et_wr = acc & wr & hit_et;
  wire cmd_wr = acc & wr & hit_cmd;
  logic [dispatch_sched_pkg::TIME_W-1:0] now;  // free-running timer
  wire [31:0] rd_val = (hit_ct & ~wb_we_i) ? {9'h000, now} : 32'h00000000;

  // bus answer: one cycle after the request is taken, then drops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack <= acc;
      wb_dat_o <= acc ? rd_val : wb_dat_o;
    end
  end
  assign wb_ack_o = ack;

  // ****************************************************
  // timer
  // ****************************************************
  // wraps naturally at the 23-bit boundary
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      now <= 23'h000000;
    end else begin
      now <= now + 23'h000001;
    end
  end

  // ****************************************************
  // dispatcher sources
  // ****************************************************
  logic sched_pend;  // scheduler start waiting for a slot
  dispatch_sched_pkg::start_req_t sched_req;
  logic [6:0] src_valid;
  dispatch_sched_pkg::start_req_t [6:0] src_req;
  dispatch_sched_pkg::start_req_t wb_req;
  assign wb_req = '{addr: wb_dat_i[dispatch_sched_pkg::START_ADDR_HI:
                                   dispatch_sched_pkg::START_ADDR_LO],
                    a0: 16'h0000, a0_load: 1'b0};
  assign src_valid = {boot_pend | launch_wr, sched_pend, periph_valid_i, 1'b0};
  assign src_req[dispatch_sched_pkg::PRIO_LAUNCH] = boot_pend ?
      '{addr: dispatch_sched_pkg::BOOT_ADDR, a0: 16'h0000, a0_load: 1'b0} : wb_req;
  assign src_req[dispatch_sched_pkg::PRIO_SCHED] = sched_req;
  assign src_req[4:1] = periph_req_i;
  assign src_req[0] = '0;

  // ****************************************************
  // slot tracking and fixed-priority pick
  // ****************************************************
  logic [dispatch_sched_pkg::NUM_SLOTS-1:0] alive;
  logic [3:0] free_id;  // lowest free slot
  logic any_free;
  logic [2:0] win;  // winning source index
  logic win_any;
  always_comb begin
    free_id = 4'h0;
    any_free = 1'b0;
    for (int i = dispatch_sched_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (!alive[i]) begin
        free_id = 4'(i);
        any_free = 1'b1;
      end
    end
    win = 3'h0;
    win_any = 1'b0;
    for (int s = 1; s < dispatch_sched_pkg::NUM_SRC; s++) begin
      if (src_valid[s]) begin
        win = 3'(s);
        win_any = 1'b1;
      end
    end
  end
  wire new_go = win_any & any_free;
  assign grant = new_go ? (7'h01 << win) : 7'h00;
  assign periph_ready_o = grant[4:1];

  // ****************************************************
  // parked thread queue
  // ****************************************************
  logic [3:0] q_mem [0:dispatch_sched_pkg::NUM_SLOTS-1];
  logic [3:0] q_rd;
  logic [3:0] q_wr;
  logic [4:0] q_cnt;
  wire q_empty = q_cnt == 5'h00;
  wire ret_ok = ret_valid_i & alive[ret_id_i];  // ended threads vanish
  wire q_pop = ~new_go & ~q_empty;
  wire q_push = ret_ok & (new_go | ~q_empty);
  wire reinsert = ret_ok & ~q_push;

  // queue pointers; a slot count of 16 keeps it from overflowing
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_rd <= 4'h0;
      q_wr <= 4'h0;
      q_cnt <= 5'h00;
    end else begin
      q_rd <= q_rd + {3'h0, q_pop};
      q_wr <= q_wr + {3'h0, q_push};
      q_cnt <= q_cnt + {4'h0, q_push} - {4'h0, q_pop};
    end
  end

  // queue storage
  always_ff @(posedge clk_i) begin
    if (q_push) begin
      q_mem[q_wr] <= ret_id_i;
    end
  end

  // ****************************************************
  // issue and slot state
  // ****************************************************
  wire [15:0] alloc_mask = new_go ? (16'h0001 << free_id) : 16'h0000;
  wire [15:0] end_mask = end_wr ? (16'h0001 << wr_thread_i) : 16'h0000;

  // one thread enters the pipeline per cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alive <= 16'h0000;
      boot_pend <= 1'b1;
      issue_valid_o <= 1'b0;
      issue_o <= '0;
    end else begin
      alive <= (alive & ~end_mask) | alloc_mask;
      boot_pend <= boot_pend & ~grant[dispatch_sched_pkg::PRIO_LAUNCH];
      if (new_go) begin
        issue_valid_o <= 1'b1;
        issue_o <= '{id: free_id, is_new: 1'b1, req: src_req[win]};
      end else if (q_pop) begin
        issue_valid_o <= alive[q_mem[q_rd]];
        issue_o <= '{id: q_mem[q_rd], is_new: 1'b0, req: '0};
      end else begin
        issue_valid_o <= reinsert;
        issue_o <= '{id: ret_id_i, is_new: 1'b0, req: '0};
      end
    end
  end

  // ****************************************************
  // per-thread command registers
  // ****************************************************
  logic [31:0] cmd_reg [0:dispatch_sched_pkg::NUM_SLOTS-1];
  always_ff @(posedge clk_i) begin
    if (cmd_wr) begin
      cmd_reg[wr_thread_i] <= wb_dat_i;
    end
  end

  // ****************************************************
  // sorted event list
  // ****************************************************
  dispatch_sched_pkg::ev_t ev_list [0:dispatch_sched_pkg::LIST_DEPTH-1];
  dispatch_sched_pkg::ev_t new_ev;
  dispatch_sched_pkg::ins_state_t ins_state;
  logic [7:0] ev_cnt;
  logic [7:0] idx;  // insertion scan position
  logic [2:0] head_cnt;
  logic served;  // one match already taken this insertion
  logic ex_start;
  wire [31:0] et_cmd = cmd_reg[wr_thread_i];
  // thread events carry no time in their word: time comes from the command
  wire [22:0] et_time = wb_dat_i[dispatch_sched_pkg::ET_THREAD_BIT] ?
      et_cmd[dispatch_sched_pkg::TIME_HI:dispatch_sched_pkg::TIME_LO] :
      wb_dat_i[dispatch_sched_pkg::TIME_HI:dispatch_sched_pkg::TIME_LO];
  // keys order events relative to now, with the look-back window in front
  wire [22:0] new_key = new_ev.time_at - now + dispatch_sched_pkg::LOOKBACK;
  wire [22:0] idx_key = ev_list[idx].time_at - now + dispatch_sched_pkg::LOOKBACK;
  wire scan_stop = (idx >= ev_cnt) | (idx_key > new_key);
  wire ins_put = ins_state == dispatch_sched_pkg::INS_PUT;
  wire idx_dec = ex_start & (idx != 8'h00);
  assign sched_busy = (ins_state != dispatch_sched_pkg::INS_IDLE) |
                      (ev_cnt == dispatch_sched_pkg::LIST_FULL);

  // insertion sequencer: head check, scan, put
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ins_state <= dispatch_sched_pkg::INS_IDLE;
      head_cnt <= 3'h0;
      idx <= 8'h00;
      served <= 1'b0;
      new_ev <= '0;
    end else begin
      served <= served | (ex_start & (ins_state == dispatch_sched_pkg::INS_SCAN));
      case (ins_state)
        dispatch_sched_pkg::INS_IDLE: begin
          if (et_wr) begin
            new_ev <= '{time_at: et_time, cmd: et_cmd, et: wb_dat_i};
            head_cnt <= 3'h0;
            served <= 1'b0;
            ins_state <= dispatch_sched_pkg::INS_HEAD;
          end
        end
        dispatch_sched_pkg::INS_HEAD: begin
          head_cnt <= head_cnt + 3'h1;
          if (head_cnt == dispatch_sched_pkg::HEAD_BLOCK - 3'h1) begin
            idx <= 8'h00;
            ins_state <= dispatch_sched_pkg::INS_SCAN;
          end
        end
        dispatch_sched_pkg::INS_SCAN: begin
          if (scan_stop) begin
            idx <= idx - {7'h00, idx_dec};
            ins_state <= dispatch_sched_pkg::INS_PUT;
          end else begin
            idx <= idx + 8'h01 - {7'h00, idx_dec};
          end
        end
        dispatch_sched_pkg::INS_PUT: begin
          ins_state <= dispatch_sched_pkg::INS_IDLE;
        end
        default: begin
          ins_state <= dispatch_sched_pkg::INS_IDLE;
        end
      endcase
    end
  end

  // entry count
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ev_cnt <= 8'h00;
    end else begin
      ev_cnt <= ev_cnt + {7'h00, ins_put} - {7'h00, ex_start};
    end
  end

  // entries from idx up shift up on insert, every entry shifts down on pop
  for (genvar gi = 0; gi < dispatch_sched_pkg::LIST_DEPTH; gi++) begin : g_ent
    dispatch_sched_pkg::ev_t below;
    dispatch_sched_pkg::ev_t above;
    if (gi == 0) begin : g_first
      assign below = new_ev;
    end else begin : g_mid
      assign below = ev_list[gi-1];
    end
    if (gi == dispatch_sched_pkg::LIST_DEPTH - 1) begin : g_last
      assign above = '0;
    end else begin : g_up
      assign above = ev_list[gi+1];
    end
    always_ff @(posedge clk_i) begin
      if (ins_put && 8'(gi) >= idx) begin
        ev_list[gi] <= (8'(gi) == idx) ? new_ev : below;
      end else if (ex_start) begin
        ev_list[gi] <= above;
      end
    end
  end

  // ****************************************************
  // command execution
  // ****************************************************
  dispatch_sched_pkg::ev_t ex_ev;  // entry being executed
  logic [3:0] ex_cnt;  // cycles since last start
  wire [22:0] late = now - ev_list[0].time_at;
  wire due = (ev_cnt != 8'h00) & (late <= dispatch_sched_pkg::LOOKBACK);
  wire ins_allows = (ins_state == dispatch_sched_pkg::INS_IDLE) |
                    ((ins_state == dispatch_sched_pkg::INS_SCAN) & ~served);
  assign ex_start = due & (ex_cnt == 4'h0) & ~sched_pend & ins_allows;
  wire ex_fire = ex_cnt == {1'b0, dispatch_sched_pkg::EXEC_CYCLES - 3'h1};
  wire ex_thread = ex_ev.et[dispatch_sched_pkg::ET_THREAD_BIT];
  wire [2:0] ex_op = ex_ev.cmd[dispatch_sched_pkg::CMD_OP_HI:dispatch_sched_pkg::CMD_OP_LO];

  // executor: five cycles to complete, eight between starts
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ex_cnt <= 4'h0;
      ex_ev <= '0;
    end else if (ex_start) begin
      ex_cnt <= 4'h1;
      ex_ev <= ev_list[0];
    end else if (ex_cnt != 4'h0) begin
      ex_cnt <= (ex_cnt == dispatch_sched_pkg::SAME_TIME_GAP - 4'h1) ? 4'h0 : ex_cnt + 4'h1;
    end
  end

  // completion: gpio pulse or held scheduler start request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gpio_cmd_valid_o <= 1'b0;
      gpio_cmd_o <= '0;
      sched_pend <= 1'b0;
      sched_req <= '0;
    end else begin
      gpio_cmd_valid_o <= ex_fire & ~ex_thread & ~ex_op[2];
      if (ex_fire & ~ex_thread) begin
        gpio_cmd_o <= '{op: ex_op,
                        port: ex_ev.cmd[dispatch_sched_pkg::CMD_PORT_HI:
                                        dispatch_sched_pkg::CMD_PORT_LO],
                        pins: ex_ev.cmd[dispatch_sched_pkg::CMD_PIN_HI:
                                        dispatch_sched_pkg::CMD_PIN_LO]};
      end
      if (ex_fire & ex_thread) begin
        sched_pend <= 1'b1;
        sched_req <= '{addr: ex_ev.et[dispatch_sched_pkg::START_ADDR_HI:
                                      dispatch_sched_pkg::START_ADDR_LO],
                       a0: ex_ev.et[dispatch_sched_pkg::ET_A0_HI:dispatch_sched_pkg::ET_A0_LO],
                       a0_load: ex_ev.et[dispatch_sched_pkg::ET_A0_LOAD_BIT]};
      end else if (grant[dispatch_sched_pkg::PRIO_SCHED]) begin
        sched_pend <= 1'b0;
      end
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire gpio_next = ~ev_list[0].et[dispatch_sched_pkg::ET_THREAD_BIT] &
                   ~ev_list[0].cmd[dispatch_sched_pkg::CMD_OP_HI];
  sequence s_exec_quiet;
    !gpio_cmd_valid_o [*4];
  endsequence
  sequence s_exec_done;
    gpio_cmd_valid_o;
  endsequence
  property p_prio;
    grant[dispatch_sched_pkg::PRIO_SCHED] |-> !src_valid[dispatch_sched_pkg::PRIO_LAUNCH];
  endproperty
  a_prio: assert property (p_prio) else $error("lower source beat higher");
  property p_full_stall;
    (alive == 16'hFFFF) |-> (grant == 7'h00);
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("start with no free slot");
  property p_issue_new;
    (grant != 7'h00) |=> issue_valid_o && issue_o.is_new;
  endproperty
  a_issue_new: assert property (p_issue_new) else $error("granted start not issued");
  property p_exec;
    (ex_start && gpio_next) |=> s_exec_quiet ##1 s_exec_done;
  endproperty
  a_exec: assert property (p_exec) else $error("gpio command not done in 5 cycles");
  property p_gap;
    ex_start |=> !ex_start [*7];
  endproperty
  a_gap: assert property (p_gap) else $error("events closer than 8 cycles");
  property p_head_block;
    (ins_state == dispatch_sched_pkg::INS_HEAD) |-> !ex_start;
  endproperty
  a_head_block: assert property (p_head_block) else $error("execution during head check");
  property p_ct_read;
    (acc && hit_ct && !wb_we_i) |=> wb_ack_o && (wb_dat_o == {9'h000, $past(now)});
  endproperty
  a_ct_read: assert property (p_ct_read) else $error("current time read wrong");
  property p_et_one;
    et_wr |=> wb_ack_o ##1 (ins_state == dispatch_sched_pkg::INS_HEAD);
  endproperty
  a_et_one: assert property (p_et_one) else $error("event-time write not one cycle");
endmodule

// File: sim/pipe_model.sv
`timescale 1ns/100ps
// ****************************************************
// pipeline model: hands each issued thread back after four stages
// ****************************************************
module pipe_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic issue_valid_i,
  input wire logic [3:0] issue_id_i,
  output logic ret_valid_o,
  output logic [3:0] ret_id_o
);
  logic [3:0] vld;  // stage occupancy
  logic [3:0] ids [4];  // thread id held in each stage
  // shift issued threads along, every one comes back to be reinserted, parked or dropped if ended
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      vld <= 4'h0;
    end else begin
      vld <= {vld[2:0], issue_valid_i};
    end
    ids[0] <= issue_id_i;
    for (int i = 1; i < 4; i++) begin
      ids[i] <= ids[i-1];
    end
  end
  assign ret_valid_o = vld[3];
  // an idle return bus shows the inverse id, never a stale copy
  assign ret_id_o = vld[3] ? ids[3] : ~ids[3];
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef dispatch_sched_pkg::issue_t iss_t;
  typedef dispatch_sched_pkg::gpio_cmd_t gc_t;
  // ****************************************************
  // signals
  // ****************************************************
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, ret_valid_i;
  logic [31:0] wb_adr_i = 32'h00000000, wb_dat_i = 32'h00000000, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'hF, wr_thread_i = 4'h0, periph_valid_i = 4'h0;
  logic [3:0] periph_ready_o, ret_id_i, g;
  logic issue_valid_o, gpio_cmd_valid_o;
  dispatch_sched_pkg::start_req_t [3:0] periph_req_i = '0;
  iss_t issue_o, it;
  gc_t gpio_cmd_o, gc;
  iss_t news [$];  // new threads seen
  gc_t cmds [$];  // gpio commands seen
  int cmd_cyc [$];  // cycle of each gpio command
  int err_total = 0, samples_checked = 0, cyc_n = 0, c_rd, cc, pc;
  always #12.5 clk_i = ~clk_i;
  // record new threads and gpio commands as they appear
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (issue_valid_o === 1'b1 && issue_o.is_new === 1'b1) news.push_back(issue_o);
    if (gpio_cmd_valid_o === 1'b1) cmds.push_back(gpio_cmd_o);
    if (gpio_cmd_valid_o === 1'b1) cmd_cyc.push_back(cyc_n);
  end
  thread_dispatch_event_scheduler thread_dispatch_event_scheduler_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wr_thread_i(wr_thread_i), .ret_valid_i(ret_valid_i),
    .ret_id_i(ret_id_i), .periph_valid_i(periph_valid_i), .periph_req_i(periph_req_i),
    .periph_ready_o(periph_ready_o), .issue_valid_o(issue_valid_o), .issue_o(issue_o),
    .gpio_cmd_valid_o(gpio_cmd_valid_o), .gpio_cmd_o(gpio_cmd_o));
  pipe_model pipe_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .issue_valid_i(issue_valid_o), .issue_id_i(issue_o.id), .ret_valid_o(ret_valid_i),
    .ret_id_o(ret_id_i));
  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic bound(input int n);
    if (n > 2000) begin
      err_total++;
      print_verdict();
    end
  endtask
  // one classic wishbone cycle, then one idle cycle
  task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      bound(n++);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    c_rd = cyc_n;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic take_new();
    int n;
    n = 0;
    while (news.size() == 0) begin
      @(posedge clk_i);
      bound(n++);
    end
    it = news.pop_front();
  endtask
  task automatic grant();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      bound(n++);
    end while (periph_ready_o === 4'h0);
    g = periph_ready_o;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_boot_launch();
    take_new();
    chk(it.id, 4'h0);
    chk(it.req.addr, dispatch_sched_pkg::BOOT_ADDR);
    bus(1'b1, dispatch_sched_pkg::ADDR_THREAD_LAUNCH, 32'hFFFFC123);
    take_new();
    chk({it.id, it.req.addr}, {4'h1, 14'h0123});
    bus(1'b0, dispatch_sched_pkg::ADDR_THREAD_LAUNCH, 32'h00000000);
    chk(rd, 32'h00000000);
    bus(1'b0, 32'h80002000, 32'h00000000);
    chk(rd, 32'h00000000);
    bus(1'b0, dispatch_sched_pkg::ADDR_SCHED_CURRENT_TIME, 32'h00000000);
    pc = rd;
    bus(1'b0, dispatch_sched_pkg::ADDR_SCHED_CURRENT_TIME, 32'h00000000);
    chk(rd - pc, 32'h00000003);
    chk(rd[31:23], 9'h000);
    $display("test boot_launch_time done");
  endtask
  task automatic t_prio();
    periph_req_i[3].addr <= 14'h0333;
    periph_req_i[0].addr <= 14'h0111;
    periph_valid_i <= 4'h9;
    grant();
    chk(g, 4'h8);
    periph_valid_i <= 4'h1;
    grant();
    chk(g, 4'h1);
    periph_valid_i <= 4'h0;
    take_new();
    chk(it.req.addr, 14'h0333);
    take_new();
    chk(it.req.addr, 14'h0111);
    $display("test priority done");
  endtask
  task automatic t_gpio();
    logic [2:0] op;
    int off;
    logic [22:0] base;  // timer value seen by the first read, since writes read back zero
    bus(1'b0, dispatch_sched_pkg::ADDR_SCHED_CURRENT_TIME, 32'h00000000);
    pc = c_rd - 1;
    base = rd[22:0];
    for (int i = 0; i < 6; i++) begin
      op = (i < 4) ? 3'(i) : 3'h3;
      off = 500 + 64 * ((i < 4) ? i : 4);
      if (i < 4) bus(1'b1, dispatch_sched_pkg::ADDR_SCHED_COMMAND, {op, 17'h00000, 4'h5, 8'hA0 + 8'(i)});
      bus(1'b1, dispatch_sched_pkg::ADDR_SCHED_EVENT_TIME, {9'h000, base + 23'(off)});
    end
    for (int i = 0; i < 6; i++) begin
      while (cmds.size() == 0) begin
        @(posedge clk_i);
        bound(cyc_n - pc - 1000);
      end
      gc = cmds.pop_front();
      cc = cmd_cyc.pop_front();
      op = (i < 4) ? 3'(i) : 3'h3;
      chk({gc.op, gc.port}, {op, 4'h5});
      chk(gc.pins, 8'hA0 + 8'((i < 4) ? i : 3));
      if (i < 5) chk((cc - pc - 500 - 64 * i) inside {[4:8]}, 1'b1);
      if (i == 5) chk(cc - off, 8);
      off = cc;
    end
    // an event time already passed, inside the look-back window, still runs
    bus(1'b1, dispatch_sched_pkg::ADDR_SCHED_EVENT_TIME, {9'h000, base});
    pc = c_rd;
    while (cmds.size() == 0) begin
      @(posedge clk_i);
      bound(cyc_n - pc);
    end
    gc = cmds.pop_front();
    cc = cmd_cyc.pop_front();
    chk(gc.pins, 8'hA3);
    chk((cc - pc) inside {[5:30]}, 1'b1);
    $display("test gpio_events done");
  endtask
  task automatic t_thread_full();
    bus(1'b0, dispatch_sched_pkg::ADDR_SCHED_CURRENT_TIME, 32'h00000000);
    bus(1'b1, dispatch_sched_pkg::ADDR_SCHED_COMMAND, {9'h000, rd[22:0] + 23'h0000C8});
    bus(1'b1, dispatch_sched_pkg::ADDR_SCHED_EVENT_TIME, {2'h3, 16'hBEEF, 14'h0042});
    take_new();
    chk({it.req.addr, it.req.a0, it.req.a0_load}, {14'h0042, 16'hBEEF, 1'b1});
    for (int i = 0; i < 11; i++) begin
      bus(1'b1, dispatch_sched_pkg::ADDR_THREAD_LAUNCH, 32'h00000200 + i);
      take_new();
    end
    periph_valid_i <= 4'h2;
    pc = 0;
    cc = 0;
    repeat (40) begin
      @(posedge clk_i);
      pc = pc | periph_ready_o[1];
      cc = cc + int'(issue_valid_o === 1'b1 && issue_o.is_new === 1'b0);
    end
    chk(pc, 0);
    chk(cc, 40);
    wr_thread_i <= 4'h1;
    // watch the stalled request while the end write is in flight: it is served at once
    fork
      bus(1'b1, dispatch_sched_pkg::ADDR_THREAD_END, 32'h12345678);
      begin
        grant();
        periph_valid_i <= 4'h0;
      end
    join
    chk(g, 4'h2);
    take_new();
    chk(it.id, 4'h1);
    $display("test thread_event_full done");
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_boot_launch();
    t_prio();
    t_gpio();
    t_thread_full();
    print_verdict();
  end
endmodule
